// ===== shared/pdt_defs.svh
// Constants of the prescaled down timer: register indices, field positions,
// reset values and timing counts.
// Assumes it is included by its bare name from the design files.
`ifndef PDT_DEFS_SVH
`define PDT_DEFS_SVH

// Register indices; the bus byte address is four times the index.
`define PDT_IDX_PRESCALER   8'hd2
`define PDT_IDX_COUNT       8'hd3
`define PDT_IDX_STATUS_CTRL 8'hd4
`define PDT_IDX_INT_STATUS  8'hd5
`define PDT_IDX_INT_MASK    8'hd6

// Field positions in the status/control register.
`define PDT_BIT_ZERO_FLAG   7
`define PDT_BIT_IRQ_ENABLE  6
`define PDT_BIT_RSV_SET     5
`define PDT_BIT_RSV_CLEAR   4
`define PDT_BIT_PRESC_INIT  3

// Field positions in the interrupt status and mask registers.
`define PDT_INT_UNDERFLOW   0
`define PDT_INT_WAKE        1

// Reset and reload values.
`define PDT_PRESC_RELOAD    7'h7f
`define PDT_COUNT_RELOAD    8'hff
`define PDT_CTRL_RESET      8'h00

// Fixed division of the core clock ahead of the prescaler.
`define PDT_CORE_DIV        12
`define PDT_DIV_LAST        4'hb

`endif

// ===== shared/pdt_pkg.sv
// Types shared by the prescaled down timer design.
// Assumes nothing of its surroundings.
package pdt_pkg;

  // Bus answer sequence of the register slave.
  typedef enum logic [0:0] {
    PDT_BUS_IDLE,
    PDT_BUS_ANSWER
  } pdt_bus_state_t;

endpackage

// ===== rtl/pdt_timer.sv
// Prescaled down timer: divide-by-12 stage, 7-bit prescaler, 8-bit counter,
// status/control register, interrupt logic and an Avalon-MM register slave.
// Assumes one 125 MHz clock, a synchronous active-low reset, and that the
// low power mode inputs come from logic on the same clock.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`include "pdt_defs.svh"

module pdt_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        wait_mode_i,
  input  wire logic        stop_mode_i,
  output logic             timer_irq_o,
  output logic             wake_o,
  output logic             irq_o
);

  // Timer state.
  logic [3:0]  div_cnt;
  logic [6:0]  prescaler;
  logic [7:0]  count;
  logic        zero_flag;
  logic        irq_enable;
  logic        prescaler_initialize;
  logic [2:0]  tap_select;
  logic        reserved_set_bit;
  logic        reserved_clear_bit;
  logic [1:0]  int_status;
  logic [1:0]  int_mask;
  pdt_pkg::pdt_bus_state_t bus_state;

  // Decoded strobes and derived ticks.
  logic        bus_req;
  logic        wr_take;
  logic        rd_take;
  logic [7:0]  reg_idx;
  logic        idx_ok;
  logic [7:0]  wdata;
  logic        wr_pre;
  logic        wr_cnt;
  logic        wr_ctrl;
  logic        wr_istat;
  logic        wr_imask;
  logic        div_tick;
  logic [6:0]  tap_mask;
  logic        counter_tick;
  logic        underflow;
  logic        flag_set;
  logic        flag_clear;
  logic [1:0]  int_events;
  logic        wake_event;
  logic [7:0]  ctrl_value;
  logic [7:0]  next_rdata;

  // Bus decode; an access takes effect at the edge where waitrequest is low.
  assign bus_req  = avs_read_i | avs_write_i;
  assign wr_take  = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
  assign rd_take  = avs_read_i & ~avs_waitrequest_o;
  assign reg_idx  = avs_address_i[9:2];
  assign idx_ok   = avs_address_i[1:0] == 2'h0;
  assign wdata    = avs_writedata_i[7:0];
  assign wr_pre   = wr_take & idx_ok & (reg_idx == `PDT_IDX_PRESCALER);
  assign wr_cnt   = wr_take & idx_ok & (reg_idx == `PDT_IDX_COUNT);
  assign wr_ctrl  = wr_take & idx_ok & (reg_idx == `PDT_IDX_STATUS_CTRL);
  assign wr_istat = wr_take & idx_ok & (reg_idx == `PDT_IDX_INT_STATUS);
  assign wr_imask = wr_take & idx_ok & (reg_idx == `PDT_IDX_INT_MASK);

  // Core clock divided by twelve; the stage holds still in STOP.
  assign div_tick = (div_cnt == `PDT_DIV_LAST) & ~stop_mode_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_cnt <= 4'h0;
    end else if (!stop_mode_i) begin
      div_cnt <= div_tick ? 4'h0 : div_cnt + 4'h1;
    end
  end

  // A tap of order n fires when the low n prescaler bits are all zero.
  assign tap_mask     = ~(7'h7f << tap_select);
  assign counter_tick = prescaler_initialize & div_tick
                        & ((prescaler & tap_mask) == 7'h00);
  assign underflow    = counter_tick & (count == 8'h00) & ~wr_cnt;

  // Prescaler: forced while initialize is low, loadable while it is high.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prescaler <= `PDT_PRESC_RELOAD;
    end else if (!prescaler_initialize) begin
      prescaler <= `PDT_PRESC_RELOAD;
    end else if (wr_pre) begin
      prescaler <= wdata[6:0];
    end else if (div_tick) begin
      if (prescaler == 7'h00) begin
        prescaler <= `PDT_PRESC_RELOAD;
      end else begin
        prescaler <= prescaler - 7'h01;
      end
    end
  end

  // Counter: a software write wins over any tick in the same cycle.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count <= `PDT_COUNT_RELOAD;
    end else if (wr_cnt) begin
      count <= wdata;
    end else if (counter_tick) begin
      if (count == 8'h00) begin
        count <= `PDT_COUNT_RELOAD;
      end else begin
        count <= count - 8'h01;
      end
    end
  end

  // Zero flag: any set source beats a software clear in the same cycle.
  assign flag_set   = underflow
                      | (wr_cnt & (wdata == 8'h00))
                      | (wr_ctrl & wdata[`PDT_BIT_ZERO_FLAG]);
  assign flag_clear = wr_ctrl & ~wdata[`PDT_BIT_ZERO_FLAG];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      zero_flag <= 1'b0;
    end else if (flag_set) begin
      zero_flag <= 1'b1;
    end else if (flag_clear) begin
      zero_flag <= 1'b0;
    end
  end

  // Control fields of the status/control register.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_enable           <= 1'b0;
      prescaler_initialize <= 1'b0;
      tap_select           <= 3'h0;
      reserved_set_bit     <= 1'b0;
      reserved_clear_bit   <= 1'b0;
    end else if (wr_ctrl) begin
      irq_enable           <= wdata[`PDT_BIT_IRQ_ENABLE];
      prescaler_initialize <= wdata[`PDT_BIT_PRESC_INIT];
      tap_select           <= wdata[2:0];
      reserved_set_bit     <= wdata[`PDT_BIT_RSV_SET];
      reserved_clear_bit   <= wdata[`PDT_BIT_RSV_CLEAR];
    end
  end

  assign ctrl_value = {zero_flag, irq_enable, reserved_set_bit,
                       reserved_clear_bit, prescaler_initialize,
                       tap_select};

  // Timer request and wake-up; STOP gives no wake.
  assign wake_event = wait_mode_i & ~stop_mode_i & zero_flag
                      & irq_enable;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      timer_irq_o <= 1'b0;
      wake_o      <= 1'b0;
    end else begin
      timer_irq_o <= zero_flag & irq_enable;
      wake_o      <= wake_event;
    end
  end

  // Sticky event bits, cleared by writing one; a new event wins.
  assign int_events = {wake_event, underflow};

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      int_status <= 2'h0;
    end else begin
      int_status <= int_events
                    | (int_status & ~(wr_istat ? wdata[1:0] : 2'h0));
    end
  end

  // Interrupt mask and the single level interrupt output.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      int_mask <= 2'h0;
    end else if (wr_imask) begin
      int_mask <= wdata[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(int_status & int_mask);
    end
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    next_rdata = 8'h00;
    if (idx_ok) begin
      case (reg_idx)
        `PDT_IDX_PRESCALER:   next_rdata = {1'b0, prescaler};
        `PDT_IDX_COUNT:       next_rdata = count;
        `PDT_IDX_STATUS_CTRL: next_rdata = ctrl_value;
        `PDT_IDX_INT_STATUS:  next_rdata = {6'h00, int_status};
        `PDT_IDX_INT_MASK:    next_rdata = {6'h00, int_mask};
        default:              next_rdata = 8'h00;
      endcase
    end
  end

  // Slave handshake: one wait cycle, then waitrequest drops for one cycle.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus_state         <= pdt_pkg::PDT_BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      case (bus_state)
        pdt_pkg::PDT_BUS_IDLE: begin
          if (bus_req) begin
            bus_state         <= pdt_pkg::PDT_BUS_ANSWER;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= {24'h00_0000, next_rdata};
          end
        end
        pdt_pkg::PDT_BUS_ANSWER: begin
          bus_state         <= pdt_pkg::PDT_BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default: begin
          bus_state         <= pdt_pkg::PDT_BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // Checks on timer behaviour.
  default clocking pdt_cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Helper copy of the written byte for checks that look back one cycle.
  logic [7:0] chk_wdata;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      chk_wdata <= 8'h00;
    end else begin
      chk_wdata <= wdata;
    end
  end

  sequence div_quiet_s;
    !div_tick [*8];
  endsequence

  div_period_a: assert property (
    div_tick |=> div_quiet_s ##4 (div_tick || stop_mode_i))
    else $error("Divide-by-twelve tick spacing wrong.");

  pre_reload_a: assert property (
    prescaler_initialize && div_tick && prescaler == 7'h00 && !wr_pre
    |=> prescaler == 7'h7f || !prescaler_initialize)
    else $error("Prescaler did not reload after zero.");

  cnt_step_a: assert property (
    counter_tick && !wr_cnt && count != 8'h00
    |=> count == $past(count) - 8'h01)
    else $error("Counter did not step down on a tick.");

  cnt_reload_a: assert property (
    underflow |=> count == 8'hff && zero_flag)
    else $error("Counter did not reload FFh at underflow.");

  // With tap code zero every prescaler step must move the counter.
  tap_zero_a: assert property (
    prescaler_initialize && tap_select == 3'h0 && div_tick && !wr_cnt
    |=> count != $past(count))
    else $error("Tap code zero missed a prescaler step.");

  init_hold_a: assert property (
    !prescaler_initialize && !wr_cnt
    |=> prescaler == 7'h7f && count == $past(count))
    else $error("Timer ran with initialize bit low.");

  write_wins_a: assert property (
    wr_cnt && counter_tick && count == 8'h00 && wdata != 8'h00
    && !zero_flag |=> count == chk_wdata && !zero_flag)
    else $error("Counter write lost to a coinciding underflow.");

  irq_level_a: assert property (
    zero_flag && irq_enable |=> timer_irq_o)
    else $error("Timer request missing while flag and enable set.");

  stop_hold_a: assert property (
    stop_mode_i && !wr_take |=> $stable(count) && $stable(prescaler)
    && !wake_o)
    else $error("Timer state moved or woke in STOP.");

  // Bus checks: one wait cycle, then a single answer cycle.
  sequence bus_answer_s;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  bus_answer_a: assert property (
    bus_state == pdt_pkg::PDT_BUS_IDLE && bus_req |=> bus_answer_s)
    else $error("Register slave answer timing wrong.");

  rd_upper_a: assert property (
    rd_take |-> avs_readdata_o[31:8] == 24'h00_0000)
    else $error("Read data upper bytes not zero.");

  rd_unused_a: assert property (
    rd_take && idx_ok && reg_idx == `PDT_IDX_PRESCALER
    |-> avs_readdata_o[7] == 1'b0)
    else $error("Prescaler register bit 7 read as one.");

  // Load, tap, flag and output checks; the written byte is seen one cycle late.
  pre_load_a: assert property (
    wr_pre && prescaler_initialize |=> prescaler == chk_wdata[6:0])
    else $error("Prescaler write did not load.");

  cnt_load_a: assert property (
    wr_cnt |=> count == chk_wdata)
    else $error("Counter write did not load.");

  tap_top_a: assert property (
    counter_tick && tap_select == 3'h7 |-> prescaler == 7'h00)
    else $error("Tap code seven ticked off the prescaler wrap.");

  flag_write_a: assert property (
    (wr_cnt && wdata == 8'h00) || (wr_ctrl && wdata[`PDT_BIT_ZERO_FLAG])
    |=> zero_flag)
    else $error("Zero flag not set by a software write.");

  flag_keep_a: assert property (
    zero_flag && !wr_ctrl |=> zero_flag)
    else $error("Zero flag cleared without a control write.");

  irq_drop_a: assert property (
    !(zero_flag && irq_enable) |=> !timer_irq_o)
    else $error("Timer request high without flag and enable.");

  wake_level_a: assert property (
    wait_mode_i && !stop_mode_i && zero_flag && irq_enable |=> wake_o)
    else $error("Enabled zero event in WAIT gave no wake.");

  // The level interrupt follows the masked sticky bits one cycle late.
  irq_out_a: assert property (
    |(int_status & int_mask) |=> irq_o)
    else $error("Interrupt output low with an unmasked event.");

  irq_quiet_a: assert property (
    !(|(int_status & int_mask)) |=> !irq_o)
    else $error("Interrupt output high with no unmasked event.");

endmodule

// ===== testbench/pdt_timer_bench.sv
// Self-checking bench for the prescaled down timer and its register slave.
// Assumes pdt_timer and pdt_defs.svh; the bench drives every port itself.
`timescale 1ns/1ps
`include "pdt_defs.svh"

module pdt_timer_bench;
  localparam logic [9:0] A_PS = 10'h348;
  localparam logic [9:0] A_CT = 10'h34c;
  localparam logic [9:0] A_SC = 10'h350;
  localparam logic [9:0] A_IS = 10'h354;
  localparam logic [9:0] A_IM = 10'h358;
  logic        clk_i, rst_n_i, avs_read_i, avs_write_i;
  logic        wait_mode_i, stop_mode_i;
  logic [9:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, seed;
  logic [3:0]  avs_byteenable_i;
  logic        avs_waitrequest_o, timer_irq_o, wake_o, irq_o;
  logic [7:0]  rd, v;
  int          num_errors, tests_run, hits;

  pdt_timer dut (
    .clk_i            (clk_i),
    .rst_n_i          (rst_n_i),
    .avs_address_i    (avs_address_i),
    .avs_read_i       (avs_read_i),
    .avs_write_i      (avs_write_i),
    .avs_writedata_i  (avs_writedata_i),
    .avs_byteenable_i (avs_byteenable_i),
    .avs_readdata_o   (avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .wait_mode_i      (wait_mode_i),
    .stop_mode_i      (stop_mode_i),
    .timer_irq_o      (timer_irq_o),
    .wake_o           (wake_o),
    .irq_o            (irq_o)
  );

  // Free-running 125 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Next value of the fixed-seed xorshift sequence.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Prescaler value after k steps from p, with reload to 7Fh after zero.
  function automatic int ps_after(input int p, input int k);
    if (k <= p) begin
      return p - k;
    end
    return 127 - ((k - p - 1) % 128);
  endfunction

  // One Avalon access; the request is held until waitrequest is seen low.
  // Only the watchdog ends a wait that never gets its answer.
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= be;
    avs_write_i <= w;
    avs_read_i <= ~w;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Compares a register byte with an expected range.
  task automatic rdc(input logic [9:0] a, input int lo, input int hi,
                     input string nm);
    bus(1'b0, a, 8'h00, 4'hf);
    tests_run++;
    if ((^rd === 1'bx) || rd < lo || rd > hi) begin
      num_errors++;
      $display("BAD %s expected %0h..%0h seen %0h", nm, lo, hi, rd);
    end
  endtask

  // Compares an output level.
  task automatic pin(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %0b seen %0b", nm, e, g);
    end
  endtask

  // Compares a count of events with the number the rules give.
  task automatic num(input string nm, input int e, input int g);
    tests_run++;
    if (g != e) begin
      num_errors++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    idle(40000);
    num_errors++;
    final_report();
  end

  // Main sequence.
  initial begin
    {avs_read_i, avs_write_i, wait_mode_i, stop_mode_i} = 4'h0;
    avs_address_i = 10'h0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'h0;
    num_errors = 0;
    tests_run = 0;
    seed = 32'h24136546;
    rst_n_i = 1'b0;
    idle(5);
    rst_n_i <= 1'b1;
    idle(1);
    rdc(A_PS, 'h7f, 'h7f, "prescaler");
    rdc(A_CT, 'hff, 'hff, "count");
    rdc(A_SC, 0, 0, "control");
    rdc(10'h35c, 0, 0, "unmapped");
    bus(1'b1, A_SC, 8'h2b, 4'h0);
    rdc(A_SC, 0, 0, "control");
    wr(A_PS, 8'h15);
    rdc(A_PS, 'h7f, 'h7f, "prescaler");
    $display("test reset done");
    stop_mode_i <= 1'b1;
    wr(A_SC, 8'h28);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      v = seed[7:0];
      wr(A_PS, v);
      rdc(A_PS, v[6:0], v[6:0], "prescaler");
      wr(A_CT, v | 8'h01);
      idle(40);
      rdc(A_CT, v | 8'h01, v | 8'h01, "count");
    end
    $display("test load done");
    stop_mode_i <= 1'b0;
    wr(A_PS, 8'h05);
    idle(120);
    rdc(A_PS, ps_after(5, 11), ps_after(5, 10), "prescaler");
    for (int n = 0; n < 8; n++) begin
      wr(A_SC, 8'h28 | n[7:0]);
      wr(A_CT, 8'hf0);
      idle(48 << n);
      rdc(A_CT, 'hf0 - 5, 'hf0 - 4, "count");
    end
    $display("test taps done");
    // Each pass lasts 37 cycles, so the divider phase moves by one and all
    // twelve phases are met once; the second write lands 18 cycles after
    // the first, so five phases underflow first and one meets the tick.
    hits = 0;
    for (int k = 0; k < 12; k++) begin
      wr(A_SC, 8'h28);
      wr(A_CT, 8'h01);
      idle(15);
      wr(A_CT, 8'h55);
      rdc(A_CT, 'h54, 'h55, "count");
      bus(1'b0, A_SC, 8'h00, 4'hf);
      if (rd[7] === 1'b1) begin
        hits++;
      end
      idle(7);
    end
    num("early underflows", 5, hits);
    $display("test write race done");
    wr(A_SC, 8'h68);
    wr(A_IM, 8'h01);
    wr(A_CT, 8'h01);
    idle(30);
    rdc(A_CT, 'hfe, 'hff, "count");
    rdc(A_SC, 'he8, 'he8, "control");
    pin("timer_irq", 1'b1, timer_irq_o);
    pin("irq", 1'b1, irq_o);
    wr(A_IM, 8'h00);
    idle(2);
    pin("irq", 1'b0, irq_o);
    wr(A_IS, 8'h01);
    rdc(A_IS, 0, 0, "int_status");
    wr(A_SC, 8'h28);
    idle(2);
    pin("timer_irq", 1'b0, timer_irq_o);
    $display("test underflow done");
    wr(A_SC, 8'h60);
    wr(A_CT, 8'h00);
    idle(40);
    rdc(A_CT, 0, 0, "count");
    rdc(A_PS, 'h7f, 'h7f, "prescaler");
    rdc(A_SC, 'he0, 'he0, "control");
    wr(A_SC, 8'h20);
    wr(A_SC, 8'ha0);
    rdc(A_SC, 'ha0, 'ha0, "control");
    $display("test flag set done");
    wait_mode_i <= 1'b1;
    wr(A_SC, 8'he0);
    idle(2);
    pin("wake", 1'b1, wake_o);
    rdc(A_IS, 2, 3, "int_status");
    stop_mode_i <= 1'b1;
    idle(3);
    pin("wake", 1'b0, wake_o);
    stop_mode_i <= 1'b0;
    wait_mode_i <= 1'b0;
    $display("test low power done");
    final_report();
  end
endmodule
